// ### rtl/reset_idle_consts.vh
/*
 Constants for the reset and idle control block: register offsets, field
 positions, reset values and timing counts. Assumes a 100 MHz mclk.
*/
`ifndef RESET_IDLE_CONSTS_VH
`define RESET_IDLE_CONSTS_VH
`define PWR_CFG_OFFSET 12'h000
`define AUX_CFG_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define CTRL_OFFSET 12'h00C
`define IDLE_BIT 0
`define PDOWN_BIT 1
`define GF0_BIT 2
`define GF1_BIT 3
`define DSPEED_BIT 0
`define BOOTMAP_BIT 0
`define PWR_CFG_RESET 8'h00
`define MIN_RST_CLKS 24
`define WDOG_PULSE_CLKS 96
`define KEY_WAKE_CLKS 1024
`define SETTLE_CLKS 8
`define RESET_PC 16'h0000
`endif

// ### rtl/reset_idle_ctrl.v
/*
 Reset, idle and power-down control with an APB register slave.
 Assumes inputs synchronous to mclk except ext_rst, which is synchronised here for the width counter and the settle countdown;
 state, wake count, settle count and clock enables take it raw; the CPU honours cpu_clk_en, mem_block and cpu_rst.
*/
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
`include "reset_idle_consts.vh"
module reset_idle_ctrl #(
  parameter MIN_RST = `MIN_RST_CLKS,
  parameter WDOG_PULSE = `WDOG_PULSE_CLKS,
  parameter KEY_WAKE = `KEY_WAKE_CLKS,
  parameter SETTLE = `SETTLE_CLKS
) (
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire ext_rst,
  input wire watchdog_expire,
  input wire boot_jump_fuse,
  input wire irq_pending,
  input wire key_wake_input,
  input wire ext_int_wake,
  output wire rst_pin_out,
  output wire rst_pin_oe,
  output wire cpu_rst,
  output wire [15:0] reset_vector,
  output wire cpu_clk_en,
  output wire periph_clk_en,
  output wire osc_run,
  output wire clk_div2,
  output wire mem_block,
  output wire boot_map_enable
);
  localparam ST_RUN = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_PDOWN = 2'd2;
  localparam ST_WAKE = 2'd3;

  reg sync1_r;
  reg sync2_r;
  reg [7:0] rst_cnt_r;
  reg warm_rst_r;
  reg [7:0] wd_cnt_r;
  reg [10:0] wake_cnt_r;
  reg [3:0] settle_cnt_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg idle_request_bit;
  reg powerdown_request_bit;
  reg general_flag_zero;
  reg general_flag_one;
  reg double_speed_mode;
  reg boot_map_r;
  reg boot_loaded_r;
  reg idle_nxt;
  reg pdown_nxt;
  reg gf0_nxt;
  reg gf1_nxt;
  reg dspeed_nxt;
  reg [10:0] wake_cnt_nxt;
  wire wd_active;
  wire wr_en;
  wire idle_clr_async;
  wire sel_pwr;
  wire sel_aux;
  wire sel_stat;
  wire sel_ctrl;

  function [2:0] decode;
    input [11:0] a;
    begin
      if (a == `PWR_CFG_OFFSET) begin
        decode = 3'h1;
      end else if (a == `AUX_CFG_OFFSET) begin
        decode = 3'h2;
      end else if (a == `STATUS_OFFSET) begin
        decode = 3'h3;
      end else if (a == `CTRL_OFFSET) begin
        decode = 3'h4;
      end else begin
        decode = 3'h0;
      end
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel & penable & (decode(paddr) == 3'h0);
  assign wr_en = psel & penable & pwrite;

  assign sel_pwr = (decode(paddr) == 3'h1);
  assign sel_aux = (decode(paddr) == 3'h2);
  assign sel_stat = (decode(paddr) == 3'h3);
  assign sel_ctrl = (decode(paddr) == 3'h4);

  // Pin synchroniser; first stage feeds only the second
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= ext_rst;
      sync2_r <= sync1_r;
    end
  end

  // Width counter in mclk periods, same count in either speed mode
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_r <= 8'h00;
      warm_rst_r <= 1'b1;
    end else if (sync2_r) begin
      if (rst_cnt_r < MIN_RST[7:0]) begin
        rst_cnt_r <= rst_cnt_r + 8'h01;
      end else begin
        warm_rst_r <= 1'b1;
      end
    end else begin
      rst_cnt_r <= 8'h00;
      warm_rst_r <= wd_active;
    end
  end

  // Watchdog reset-out pulse
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt_r <= 8'h00;
    end else if (wd_cnt_r != 8'h00) begin
      wd_cnt_r <= wd_cnt_r - 8'h01;
    end else if (watchdog_expire) begin
      wd_cnt_r <= WDOG_PULSE[7:0];
    end
  end
  assign wd_active = (wd_cnt_r != 8'h00);
  assign rst_pin_out = wd_active;
  assign rst_pin_oe = wd_active;

  // Held through the whole pulse, released after it ends
  assign cpu_rst = warm_rst_r | wd_active;
  assign reset_vector = `RESET_PC;

  // Pin level clears idle without a clock edge
  assign idle_clr_async = ext_rst | ~rst_b;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (powerdown_request_bit) begin
          state_nxt = ST_PDOWN;
        end else if (idle_request_bit) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          state_nxt = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (key_wake_input | ext_int_wake) begin
          state_nxt = ST_WAKE;
        end
      end
      default: begin
        if (wake_cnt_r == 11'h000 && !ext_int_wake) begin
          state_nxt = ST_RUN;
        end
      end
    endcase
  end

  // Key wake holds the peripherals off while the oscillator restarts
  always @* begin
    wake_cnt_nxt = wake_cnt_r;
    if (warm_rst_r | ext_rst) begin
      wake_cnt_nxt = 11'h000;
    end else if (state_r == ST_PDOWN && state_nxt == ST_WAKE) begin
      wake_cnt_nxt = key_wake_input ? KEY_WAKE[10:0] : 11'h000;
    end else if (wake_cnt_r != 11'h000) begin
      wake_cnt_nxt = wake_cnt_r - 11'h001;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_RUN;
      wake_cnt_r <= 11'h000;
    end else begin
      wake_cnt_r <= wake_cnt_nxt;
      if (warm_rst_r | ext_rst) begin
        state_r <= ST_RUN;
      end else begin
        state_r <= state_nxt;
      end
    end
  end

  // Hardware clear beats a software write; clearing stops re-entry
  always @* begin
    idle_nxt = idle_request_bit;
    pdown_nxt = powerdown_request_bit;
    if (warm_rst_r) begin
      idle_nxt = 1'b0;
      pdown_nxt = 1'b0;
    end else if ((state_r == ST_IDLE && irq_pending) || state_nxt == ST_WAKE) begin
      idle_nxt = 1'b0;
      pdown_nxt = 1'b0;
    end else if (wr_en && sel_pwr) begin
      idle_nxt = pwdata[`IDLE_BIT];
      pdown_nxt = pwdata[`PDOWN_BIT];
    end
  end

  always @(posedge mclk or posedge idle_clr_async) begin
    if (idle_clr_async) begin
      idle_request_bit <= 1'b0;
      powerdown_request_bit <= 1'b0;
    end else begin
      idle_request_bit <= idle_nxt;
      powerdown_request_bit <= pdown_nxt;
    end
  end

  // Flags and speed mode are plain software state
  always @* begin
    gf0_nxt = general_flag_zero;
    gf1_nxt = general_flag_one;
    dspeed_nxt = double_speed_mode;
    if (warm_rst_r) begin
      gf0_nxt = 1'b0;
      gf1_nxt = 1'b0;
      dspeed_nxt = 1'b0;
    end else if (wr_en && sel_pwr) begin
      gf0_nxt = pwdata[`GF0_BIT];
      gf1_nxt = pwdata[`GF1_BIT];
    end else if (wr_en && sel_ctrl) begin
      dspeed_nxt = pwdata[`DSPEED_BIT];
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      general_flag_zero <= 1'b0;
      general_flag_one <= 1'b0;
      double_speed_mode <= 1'b0;
    end else begin
      general_flag_zero <= gf0_nxt;
      general_flag_one <= gf1_nxt;
      double_speed_mode <= dspeed_nxt;
    end
  end

  // Fuse caught on the first clock after cpu_rst releases, never in async branch
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_map_r <= 1'b0;
      boot_loaded_r <= 1'b0;
    end else if (cpu_rst) begin
      boot_loaded_r <= 1'b0;
    end else if (!boot_loaded_r) begin
      boot_map_r <= boot_jump_fuse;
      boot_loaded_r <= 1'b1;
    end else if (wr_en && sel_aux) begin
      boot_map_r <= pwdata[`BOOTMAP_BIT];
    end
  end
  assign boot_map_enable = boot_map_r;

  // RAM locked from reset-pin exit of a low-power mode until the SETTLE count runs out, counting only while the synchronised pin is low
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      settle_cnt_r <= 4'h0;
    end else if (ext_rst && state_r != ST_RUN) begin
      settle_cnt_r <= SETTLE[3:0];
    end else if (settle_cnt_r != 4'h0 && !sync2_r) begin
      settle_cnt_r <= settle_cnt_r - 4'h1;
    end
  end
  assign mem_block = (settle_cnt_r != 4'h0);

  // CPU stopped while gated; state held because the core sees no edge
  // Pin level restores the clocks at once, except periph_clk_en during a key-wake count, which waits for the next edge
  assign cpu_clk_en = ((state_r == ST_RUN) | ext_rst) & ~idle_request_bit &
    ~powerdown_request_bit;
  assign periph_clk_en = ((state_r != ST_PDOWN) | ext_rst) &
    (wake_cnt_r == 11'h000);
  assign osc_run = (state_r != ST_PDOWN) | ext_rst;
  assign clk_div2 = ~double_speed_mode;

  // Unused bits and unmapped offsets read as zero
  function [31:0] read_word;
    input [2:0] sel;
    begin
      if (sel == 3'h1) begin
        read_word = {28'h0000000, general_flag_one, general_flag_zero,
          powerdown_request_bit, idle_request_bit};
      end else if (sel == 3'h2) begin
        read_word = {31'h00000000, boot_map_r};
      end else if (sel == 3'h3) begin
        read_word = {26'h0000000, mem_block, wd_active, cpu_rst, 1'b0, state_r};
      end else if (sel == 3'h4) begin
        read_word = {31'h00000000, double_speed_mode};
      end else begin
        read_word = 32'h00000000;
      end
    end
  endfunction

  // Loaded in the setup cycle so the access phase needs no wait
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_word({sel_ctrl, sel_stat | sel_aux, sel_stat | sel_pwr});
    end
  end
endmodule

// ### bench/rst_circuit.sv
/* Model of the board reset circuit on the reset pin.
   Assumes go is a one-cycle request and len is held with it. */
`timescale 1ns/10ps
module rst_circuit (
  input wire mclk,
  input wire go,
  input wire [5:0] len,
  output logic ext_rst
);
  logic [5:0] cnt = 6'h00;
  // Pull-down holds the pin low until a request
  assign ext_rst = cnt != 6'h00;
  always @(posedge mclk) begin
    if (go) cnt <= len;
    else if (cnt != 6'h00) cnt <= cnt - 6'h01;
  end
endmodule

// ### bench/reset_idle_assertions.sv
/* Port checker for the reset and idle block.
   Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/10ps
module ri_checker #(parameter MIN_RST = 24, parameter WDOG_PULSE = 96) (
  input wire mclk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire ext_rst,
  input wire watchdog_expire,
  input wire irq_pending,
  input wire rst_pin_oe,
  input wire cpu_rst,
  input wire cpu_clk_en,
  input wire periph_clk_en,
  input wire osc_run
);
  int wcnt;
  int ecnt;
  wire wr0 = psel && penable && pwrite && paddr == 12'h000 && !cpu_rst && !ext_rst;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wcnt <= 0;
      ecnt <= 0;
    end else begin
      wcnt <= rst_pin_oe ? wcnt + 1 : 0;
      ecnt <= ext_rst ? ecnt + 1 : 0;
    end
  end
  a_wd_start: assert property (watchdog_expire && !rst_pin_oe |=> rst_pin_oe)
    else $error("pulse not started");
  a_wd_length: assert property ($fell(rst_pin_oe) |-> wcnt == WDOG_PULSE)
    else $error("pulse length wrong");
  a_wd_holds_rst: assert property (rst_pin_oe |-> cpu_rst)
    else $error("reset dropped in pulse");
  a_pin_qualify: assert property ($rose(cpu_rst) && !rst_pin_oe |-> ecnt >= MIN_RST)
    else $error("short pin accepted");
  a_pin_latest: assert property (ecnt > MIN_RST + 4 |-> cpu_rst)
    else $error("long pin ignored");
  a_idle_entry: assert property (wr0 && pwdata[1:0] == 2'b01 |=> !cpu_clk_en && periph_clk_en)
    else $error("idle not entered");
  a_pdown_entry: assert property (wr0 && pwdata[1:0] == 2'b11 |-> ##2 !osc_run && !periph_clk_en)
    else $error("power-down not entered");
  a_irq_exit: assert property (irq_pending && !cpu_clk_en && periph_clk_en |-> ##[1:3] cpu_clk_en)
    else $error("idle not left");
  a_rst_clears: assert property (ext_rst |-> cpu_clk_en && osc_run)
    else $error("pin did not clear request");
  c_wd: cover property ($fell(rst_pin_oe));
  c_wake: cover property (irq_pending && !cpu_clk_en ##1 cpu_clk_en);
  c_pin: cover property ($rose(cpu_rst));
endmodule
bind reset_idle_ctrl ri_checker #(.MIN_RST(MIN_RST), .WDOG_PULSE(WDOG_PULSE)) chk (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .ext_rst(ext_rst), .watchdog_expire(watchdog_expire),
  .irq_pending(irq_pending), .rst_pin_oe(rst_pin_oe), .cpu_rst(cpu_rst),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run));

// ### bench/tb.sv
/* Testbench: APB master and reset source.
   Assumes the block, checker and reset source model are compiled first. */
`timescale 1ns/10ps
module tb;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] len = 6'h00;
  logic pready, pslverr, se, fuse = 0, irq = 0, key = 0, wd = 0;
  logic ext_rst, pout, poe, cpu_rst, cen, pen, osc, div2, mblk, bmap;
  logic [15:0] vec;
  int fails = 0, checked = 0, n, pc, nm;
  // Short wake count keeps the run brief
  localparam int KW = 16;
  always #5 mclk = ~mclk;
  rst_circuit src (.mclk(mclk), .go(go), .len(len), .ext_rst(ext_rst));
  reset_idle_ctrl #(.KEY_WAKE(KW)) dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_rst(ext_rst), .watchdog_expire(wd),
    .boot_jump_fuse(fuse), .irq_pending(irq), .key_wake_input(key), .ext_int_wake(1'b0),
    .rst_pin_out(pout), .rst_pin_oe(poe), .cpu_rst(cpu_rst), .reset_vector(vec),
    .cpu_clk_en(cen), .periph_clk_en(pen), .osc_run(osc), .clk_div2(div2),
    .mem_block(mblk), .boot_map_enable(bmap));
  task stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task automatic wt(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      $display("[FAIL] %0t wait timed out", $time);
    end
    #1;
  endtask
  task pulse(input logic [5:0] l);
    @(posedge mclk);
    go <= 1;
    len <= l;
    @(posedge mclk);
    go <= 0;
    n = 0;
    nm = 0;
    repeat (40) begin
      @(posedge mclk);
      n += (cpu_rst === 1);
      nm += (mblk === 1);
    end
    #1;
  endtask
  initial begin
    n = $urandom(14);
    fuse = n[0];
    repeat (8) @(posedge mclk);
    rst_b <= 1;
    repeat (3) @(posedge mclk);
    #1;
    chk(cpu_rst, 0);
    chk(vec, 0);
    chk(bmap, fuse);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(0, 12'h010, 0);
    chk(se, 1);
    pc = $urandom & 12;
    apb(1, 12'h000, pc | 1);
    chk(cen, 0);
    chk(pen, 1);
    irq <= 1;
    wt(cen, 1);
    irq <= 0;
    apb(0, 12'h000, 0);
    chk(rd, pc);
    apb(1, 12'h000, pc | 3);
    @(posedge mclk);
    #1;
    chk(osc, 0);
    chk(pen, 0);
    key <= 1;
    wt(cen, 1);
    key <= 0;
    chk(n >= KW, 1);
    apb(0, 12'h008, 0);
    chk(rd[1:0], 0);
    // Same short pulse refused in both speed modes
    for (int m = 0; m < 2; m++) begin
      apb(1, 12'h00C, m);
      chk(div2, !m);
      pulse(20);
      chk(n, 0);
      chk(nm, 0);
    end
    apb(1, 12'h000, pc | 1);
    fuse <= ~fuse;
    pulse(30);
    chk(n > 0, 1);
    chk(nm > 0, 1);
    chk(bmap, fuse);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    wd <= 1;
    @(posedge mclk);
    wd <= 0;
    n = 0;
    repeat (120) begin
      @(posedge mclk);
      n += (poe === 1 && pout === 1);
    end
    chk(n, 96);
    wt(cpu_rst, 0);
    stop_test;
  end
  initial begin
    #300000;
    fails++;
    stop_test;
  end
endmodule
